//--- logic/afsc_core.sv
// command interpreter for request sense, seek and set features
`default_nettype none
module afsc_core #(
    parameter logic [2:0] MAX_PIO   = 3'h6,
    parameter logic [2:0] MAX_MDMA  = 3'h4,
    parameter logic [2:0] MAX_UDMA  = 3'h4,
    parameter logic [3:0] MAX_HEAD  = 4'hF,
    parameter logic [15:0] MAX_CYL  = 16'hFFFF,
    parameter logic [27:0] MAX_LBA  = 28'h0FFFFFF
) (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    // command from the host
    input  wire logic                  i_cmd_valid,
    input  wire logic [7:0]            i_cmd_code,
    input  wire afsc_pkg::afsc_taskfile_t i_taskfile,
    // environment
    input  wire logic                  i_pc_card_mode,
    input  wire logic                  i_data_reg_access,
    input  wire logic                  i_flush_done,
    input  wire logic                  i_event_valid,
    input  wire afsc_pkg::afsc_event_t i_event,
    // answers to the host
    output logic                       o_busy,
    output logic                       o_done,
    output logic                       o_error,
    output logic [7:0]                 o_error_reg,
    output logic [7:0]                 o_sense_code,
    output logic [7:0]                 o_cyl_lo,
    output logic [7:0]                 o_cyl_hi,
    // state outputs
    output logic                       o_flush_req,
    output logic                       o_sixteen_bit_io_indicator,
    output logic                       o_iordy_drive,
    output afsc_pkg::afsc_cfg_t        o_cfg
);
    import afsc_pkg::*;

    typedef enum logic [2:0] {
        AFSC_IDLE  = 3'b001,
        AFSC_FLUSH = 3'b010,
        AFSC_DONE  = 3'b100
    } afsc_state_t;

    afsc_state_t state;
    afsc_cfg_t   cfg;
    afsc_cfg_t   next_cfg;
    logic [7:0]  sense;
    logic        next_ok;
    logic        x_valid;
    logic        x_pio;
    logic        x_mdma;
    logic        x_udma;
    logic [2:0]  x_mode;
    logic        x_iordy_off;
    logic        addr_bad;
    logic        addr_over;
    logic [27:0] lba_addr;

    function automatic logic [7:0] ev_code(input afsc_event_t ev);
        case (ev)
            AFSC_EV_SELFTEST: ev_code = EE_SELFTEST;
            AFSC_EV_MISC:     ev_code = EE_MISC;
            AFSC_EV_BAD_ADDR: ev_code = EE_BAD_ADDR;
            AFSC_EV_OVERFLOW: ev_code = EE_OVERFLOW;
            AFSC_EV_VOLT:     ev_code = EE_VOLT;
            AFSC_EV_VOLT_INT: ev_code = EE_VOLT_INT;
            AFSC_EV_UNCORR:   ev_code = EE_UNCORR;
            AFSC_EV_CORR:     ev_code = EE_CORR;
            AFSC_EV_DIAG:     ev_code = EE_DIAG;
            AFSC_EV_IDNF:     ev_code = EE_IDNF;
            AFSC_EV_SPARE:    ev_code = EE_SPARE;
            AFSC_EV_XFER_ERR: ev_code = EE_ABORT;
            AFSC_EV_WR_FAIL:  ev_code = EE_WR_FAIL;
            default:          ev_code = EE_NONE;
        endcase
    endfunction

    function automatic afsc_cfg_t cfg_default();
        afsc_cfg_t c;
        c             = '0;
        c.look_ahead  = 1'b1;
        c.por_on_soft = 1'b1;
        c.current_lim = 8'hFF;
        c.long4       = 1'b1;
        cfg_default   = c;
    endfunction

    afsc_xfer_dec #(
        .MAX_PIO  (MAX_PIO),
        .MAX_MDMA (MAX_MDMA),
        .MAX_UDMA (MAX_UDMA)
    ) u_dec (
        .i_value        (i_taskfile.sec_count),
        .i_pc_card_mode (i_pc_card_mode),
        .o_valid        (x_valid),
        .o_is_pio       (x_pio),
        .o_is_mdma      (x_mdma),
        .o_is_udma      (x_udma),
        .o_mode         (x_mode),
        .o_iordy_off    (x_iordy_off)
    );

    // seek range check
    assign lba_addr  = {i_taskfile.head, i_taskfile.cyl_hi, i_taskfile.cyl_lo,
                        i_taskfile.sec_num};
    assign addr_bad  = !i_taskfile.lba && (i_taskfile.head > MAX_HEAD);
    assign addr_over = i_taskfile.lba ? (lba_addr > MAX_LBA)
                     : ({i_taskfile.cyl_hi, i_taskfile.cyl_lo} > MAX_CYL);

    // subcommand decode; any unknown value leaves cfg as it was
    always_comb begin
        next_cfg = cfg;
        next_ok  = 1'b1;
        case (i_taskfile.features)
            SF_8BIT_ON:  next_cfg.eight_bit   = 1'b1;
            SF_8BIT_OFF: next_cfg.eight_bit   = 1'b0;
            SF_WC_ON:    next_cfg.write_cache = 1'b1;
            SF_WC_OFF:   next_cfg.write_cache = 1'b0;
            SF_XFER: begin
                if (!x_valid) begin
                    next_ok = 1'b0;
                end else if (x_pio) begin
                    // zero value or the default type reverts to pio 0
                    next_cfg.pio_mode  = (i_taskfile.sec_count[7:3] == XT_PIO_DEF)
                                       ? 3'h0 : x_mode;
                    next_cfg.iordy_off = x_iordy_off;
                end else if (x_mdma) begin
                    next_cfg.mdma_on  = 1'b1;
                    next_cfg.udma_on  = 1'b0;
                    next_cfg.dma_mode = x_mode;
                end else begin
                    next_cfg.udma_on  = 1'b1;
                    next_cfg.mdma_on  = 1'b0;
                    next_cfg.dma_mode = x_mode;
                end
            end
            SF_APM_ON: begin
                next_cfg.apm_on    = 1'b1;
                next_cfg.apm_level = i_taskfile.sec_count;
            end
            SF_APM_OFF:  next_cfg.apm_on      = 1'b0;
            SF_XPWR_ON:  next_cfg.xpwr_on     = 1'b1;
            SF_XPWR_OFF: next_cfg.xpwr_on     = 1'b0;
            SF_PL1_ON:   next_cfg.pl1_on      = 1'b1;
            SF_PL1_OFF:  next_cfg.pl1_on      = 1'b0;
            SF_RLA_OFF:  next_cfg.look_ahead  = 1'b0;
            SF_RLA_ON:   next_cfg.look_ahead  = 1'b1;
            SF_POR_OFF:  next_cfg.por_on_soft = 1'b0;
            SF_POR_ON:   next_cfg.por_on_soft = 1'b1;
            SF_NOP_A, SF_NOP_B, SF_LEGACY: next_ok = 1'b1;
            SF_CURRENT:  next_cfg.current_lim = i_taskfile.sec_count;
            SF_LONG4:    next_cfg.long4       = 1'b1;
            default:     next_ok = 1'b0;
        endcase
    end

    // command sequencing
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state  <= AFSC_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state)
                AFSC_IDLE: begin
                    if (i_cmd_valid) begin
                        o_busy <= 1'b1;
                        if (i_cmd_code == CMD_SETFEAT && i_taskfile.features == SF_WC_OFF
                            && cfg.write_cache) begin
                            state <= AFSC_FLUSH;
                        end else begin
                            state <= AFSC_DONE;
                        end
                    end
                end
                AFSC_FLUSH: begin
                    // completion waits for the flush; no timeout on purpose
                    if (i_flush_done) begin
                        state <= AFSC_DONE;
                    end
                end
                AFSC_DONE: begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    state  <= AFSC_IDLE;
                end
                default: state <= AFSC_IDLE;
            endcase
        end
    end

    // flush request towards the media side
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_flush_req <= 1'b0;
        end else begin
            o_flush_req <= (state == AFSC_IDLE) && i_cmd_valid
                        && i_cmd_code == CMD_SETFEAT && i_taskfile.features == SF_WC_OFF
                        && cfg.write_cache;
        end
    end

    // configuration update, taken when the command is accepted
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cfg <= cfg_default();
        end else if (state == AFSC_IDLE && i_cmd_valid && i_cmd_code == CMD_SETFEAT
                     && next_ok) begin
            cfg <= next_cfg;
        end
    end

    // error register, outcome status and sense code
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sense       <= EE_NONE;
            o_error     <= 1'b0;
            o_error_reg <= 8'h00;
            o_cyl_lo    <= 8'h00;
            o_cyl_hi    <= 8'h00;
        end else if (state == AFSC_IDLE && i_cmd_valid) begin
            o_error     <= 1'b0;
            o_error_reg <= 8'h00;
            if (i_cmd_code == CMD_SENSE) begin
                o_error_reg <= sense;
                sense       <= EE_NONE;
            end else if (i_cmd_code[7:4] == CMD_SEEK_HI) begin
                if (addr_bad || addr_over) begin
                    o_error                  <= 1'b1;
                    o_error_reg[ERR_IDNF_BIT] <= 1'b1;
                    sense <= addr_over ? EE_OVERFLOW : EE_BAD_ADDR;
                end else begin
                    sense <= EE_NONE;
                end
            end else if (i_cmd_code == CMD_SETFEAT) begin
                if (!next_ok) begin
                    o_error                  <= 1'b1;
                    o_error_reg[ERR_ABRT_BIT] <= 1'b1;
                    sense                    <= EE_ABORT;
                end else begin
                    sense <= EE_NONE;
                end
                if (i_taskfile.features == SF_CURRENT) begin
                    o_cyl_lo <= 8'h01;
                    o_cyl_hi <= 8'hFF;
                end
            end
        end else if (i_event_valid) begin
            sense <= ev_code(i_event);
        end
    end

    // pin-level outputs derived from the settings, plus the registered sense code
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sixteen_bit_io_indicator <= 1'b0;
            o_iordy_drive              <= 1'b0;
            o_cfg                      <= cfg_default();
            o_sense_code               <= EE_NONE;
        end else begin
            o_sixteen_bit_io_indicator <= i_data_reg_access && !cfg.eight_bit;
            o_iordy_drive              <= (cfg.pio_mode >= PIO_IORDY_MIN);
            o_cfg                      <= cfg;
            o_sense_code               <= sense;
        end
    end

    a_sense_return: assert property (@(posedge i_clk) disable iff (i_reset)
        state == AFSC_IDLE && i_cmd_valid && i_cmd_code == CMD_SENSE
        |=> o_error_reg == $past(sense))
        else $error("sense code not returned");
    a_seek_range: assert property (@(posedge i_clk) disable iff (i_reset)
        state == AFSC_IDLE && i_cmd_valid && i_cmd_code[7:4] == CMD_SEEK_HI
        && (addr_bad || addr_over) |=> o_error && sense != EE_NONE)
        else $error("seek range error missed");
    a_abort_keeps: assert property (@(posedge i_clk) disable iff (i_reset)
        state == AFSC_IDLE && i_cmd_valid && i_cmd_code == CMD_SETFEAT && !next_ok
        |=> $stable(cfg) && o_error && sense == EE_ABORT)
        else $error("bad subcommand not aborted");
    a_dma_exclusive: assert property (@(posedge i_clk) disable iff (i_reset)
        !(cfg.mdma_on && cfg.udma_on))
        else $error("both dma kinds enabled");
    a_iordy_level: assert property (@(posedge i_clk) disable iff (i_reset)
        ##1 o_iordy_drive == ($past(cfg.pio_mode) >= PIO_IORDY_MIN))
        else $error("iordy drive wrong");
    a_flush_first: assert property (@(posedge i_clk) disable iff (i_reset)
        state == AFSC_FLUSH && !i_flush_done |=> !o_done)
        else $error("completion before flush");
    a_no_mdma_pc: assert property (@(posedge i_clk) disable iff (i_reset)
        state == AFSC_IDLE && i_cmd_valid && i_cmd_code == CMD_SETFEAT
        && i_taskfile.features == SF_XFER && x_mdma && i_pc_card_mode
        |=> !$past(cfg.mdma_on) |-> !cfg.mdma_on)
        else $error("mdma accepted in pc card mode");
    a_eight_bit: assert property (@(posedge i_clk) disable iff (i_reset)
        cfg.eight_bit && $stable(cfg.eight_bit) |=> !o_sixteen_bit_io_indicator)
        else $error("16-bit indicator in 8-bit mode");
    a_zero_pio: assert property (@(posedge i_clk) disable iff (i_reset)
        state == AFSC_IDLE && i_cmd_valid && i_cmd_code == CMD_SETFEAT
        && i_taskfile.features == SF_XFER && i_taskfile.sec_count == 8'h00
        |=> cfg.pio_mode == 3'h0 && !cfg.iordy_off)
        else $error("zero value did not revert pio");
    c_flush: cover property (@(posedge i_clk) state == AFSC_FLUSH ##1 state == AFSC_DONE);
    c_udma: cover property (@(posedge i_clk) cfg.udma_on);
    c_abort: cover property (@(posedge i_clk) o_error && o_error_reg[ERR_ABRT_BIT]);
    c_sense: cover property (@(posedge i_clk) o_done && o_error_reg == EE_ABORT);
endmodule
`default_nettype wire

//--- logic/afsc_pkg.sv
// package for the task-file feature, sense and seek command block
`default_nettype none
package afsc_pkg;
    // command codes
    localparam logic [7:0] CMD_SENSE     = 8'h03;
    localparam logic [3:0] CMD_SEEK_HI   = 4'h7;
    localparam logic [7:0] CMD_SETFEAT   = 8'hEF;
    // set-features subcommands
    localparam logic [7:0] SF_8BIT_ON    = 8'h01;
    localparam logic [7:0] SF_8BIT_OFF   = 8'h81;
    localparam logic [7:0] SF_WC_ON      = 8'h02;
    localparam logic [7:0] SF_WC_OFF     = 8'h82;
    localparam logic [7:0] SF_XFER       = 8'h03;
    localparam logic [7:0] SF_APM_ON     = 8'h05;
    localparam logic [7:0] SF_APM_OFF    = 8'h85;
    localparam logic [7:0] SF_XPWR_ON    = 8'h09;
    localparam logic [7:0] SF_XPWR_OFF   = 8'h89;
    localparam logic [7:0] SF_PL1_ON     = 8'h0A;
    localparam logic [7:0] SF_PL1_OFF    = 8'h8A;
    localparam logic [7:0] SF_RLA_OFF    = 8'h55;
    localparam logic [7:0] SF_RLA_ON     = 8'hAA;
    localparam logic [7:0] SF_POR_OFF    = 8'h66;
    localparam logic [7:0] SF_POR_ON     = 8'hCC;
    localparam logic [7:0] SF_NOP_A      = 8'h69;
    localparam logic [7:0] SF_NOP_B      = 8'h96;
    localparam logic [7:0] SF_LEGACY     = 8'h97;
    localparam logic [7:0] SF_CURRENT    = 8'h9A;
    localparam logic [7:0] SF_LONG4      = 8'hBB;
    // transfer type field (sector count bits 7:3)
    localparam logic [4:0] XT_PIO_DEF    = 5'h00;
    localparam logic [4:0] XT_PIO_FC     = 5'h01;
    localparam logic [4:0] XT_MDMA       = 5'h04;
    localparam logic [4:0] XT_UDMA       = 5'h08;
    localparam logic [2:0] XM_NO_IORDY   = 3'h1;
    localparam logic [2:0] PIO_IORDY_MIN = 3'h3;
    // extended error codes
    localparam logic [7:0] EE_NONE       = 8'h00;
    localparam logic [7:0] EE_SELFTEST   = 8'h01;
    localparam logic [7:0] EE_WR_FAIL    = 8'h03;
    localparam logic [7:0] EE_DIAG       = 8'h05;
    localparam logic [7:0] EE_MISC       = 8'h09;
    localparam logic [7:0] EE_IDNF       = 8'h10;
    localparam logic [7:0] EE_IDNF2      = 8'h14;
    localparam logic [7:0] EE_UNCORR     = 8'h11;
    localparam logic [7:0] EE_CORR       = 8'h18;
    localparam logic [7:0] EE_ABORT      = 8'h1F;
    localparam logic [7:0] EE_BAD_ADDR   = 8'h21;
    localparam logic [7:0] EE_OVERFLOW   = 8'h2F;
    localparam logic [7:0] EE_VOLT       = 8'h35;
    localparam logic [7:0] EE_VOLT_INT   = 8'h36;
    localparam logic [7:0] EE_SPARE      = 8'h3A;
    // error register bits
    localparam int         ERR_ABRT_BIT  = 2;
    localparam int         ERR_IDNF_BIT  = 4;
    // outcome events from the rest of the card
    typedef enum logic [3:0] {
        AFSC_EV_NONE, AFSC_EV_SELFTEST, AFSC_EV_MISC, AFSC_EV_BAD_ADDR,
        AFSC_EV_OVERFLOW, AFSC_EV_VOLT, AFSC_EV_VOLT_INT, AFSC_EV_UNCORR,
        AFSC_EV_CORR, AFSC_EV_DIAG, AFSC_EV_IDNF, AFSC_EV_SPARE,
        AFSC_EV_XFER_ERR, AFSC_EV_WR_FAIL
    } afsc_event_t;
    // task file as written by the host
    typedef struct packed {
        logic [7:0] features;
        logic [7:0] sec_count;
        logic [7:0] sec_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic       lba;
        logic [3:0] head;
    } afsc_taskfile_t;
    // settings held by the block
    typedef struct packed {
        logic       eight_bit;
        logic       write_cache;
        logic [2:0] pio_mode;
        logic       iordy_off;
        logic       mdma_on;
        logic       udma_on;
        logic [2:0] dma_mode;
        logic       apm_on;
        logic [7:0] apm_level;
        logic       xpwr_on;
        logic       pl1_on;
        logic       look_ahead;
        logic       por_on_soft;
        logic [7:0] current_lim;
        logic       long4;
    } afsc_cfg_t;
endpackage
`default_nettype wire

//--- logic/afsc_xfer_dec.sv
// decoder of the set-transfer-mode sector count value
`default_nettype none
module afsc_xfer_dec #(
    parameter logic [2:0] MAX_PIO  = 3'h6,
    parameter logic [2:0] MAX_MDMA = 3'h4,
    parameter logic [2:0] MAX_UDMA = 3'h4
) (
    // value and interface mode
    input  wire logic [7:0] i_value,
    input  wire logic       i_pc_card_mode,
    // decoded selection
    output logic            o_valid,
    output logic            o_is_pio,
    output logic            o_is_mdma,
    output logic            o_is_udma,
    output logic [2:0]      o_mode,
    output logic            o_iordy_off
);
    import afsc_pkg::*;
    logic [4:0] xtype;
    assign xtype = i_value[7:3];
    assign o_mode = i_value[2:0];
    always_comb begin
        o_valid     = 1'b0;
        o_is_pio    = 1'b0;
        o_is_mdma   = 1'b0;
        o_is_udma   = 1'b0;
        o_iordy_off = 1'b0;
        case (xtype)
            XT_PIO_DEF: begin
                o_is_pio    = 1'b1;
                o_iordy_off = (i_value[2:0] == XM_NO_IORDY);
                o_valid     = (i_value[2:0] == 3'h0) || o_iordy_off;
            end
            XT_PIO_FC: begin
                o_is_pio = 1'b1;
                o_valid  = (i_value[2:0] <= MAX_PIO);
            end
            XT_MDMA: begin
                o_is_mdma = 1'b1;
                // multiword dma is barred in the pc card modes
                o_valid   = (i_value[2:0] <= MAX_MDMA) && !i_pc_card_mode;
            end
            XT_UDMA: begin
                o_is_udma = 1'b1;
                o_valid   = (i_value[2:0] <= MAX_UDMA);
            end
            default: o_valid = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

//--- test/afsc_host.sv
// host model that writes the task file and issues one command at a time
`default_nettype none
module afsc_host (
    // clock and completion
    input  wire logic                  i_clk,
    input  wire logic                  i_done,
    // command to the card
    output var logic                   o_cmd_valid,
    output var logic [7:0]             o_cmd_code,
    output var afsc_pkg::afsc_taskfile_t o_taskfile
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_cmd_valid = 1'b0;
    initial o_cmd_code = 8'h00;
    initial o_taskfile = '0;
    // waits up to 40 cycles for completion before returning, so requests do not overlap
    task automatic issue(input logic [7:0] c, input afsc_pkg::afsc_taskfile_t t,
                         output logic ok);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_code <= c;
        o_taskfile <= t;
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge i_clk);
            #1 ok = (i_done === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

//--- test/ata_feature_sense_seek_cmds_tb.sv
// bench for the request sense, seek and set features block
`default_nettype none
module ata_feature_sense_seek_cmds_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import afsc_pkg::*;
    logic clk = 0, reset = 1, pc = 0, dra = 0, fdone = 0, evv = 0, fl = 0, ok;
    logic cv, busy, done, err, freq, ind, iordy;
    logic [7:0] code, ereg, sense, clo, chi;
    afsc_taskfile_t tf;
    afsc_event_t ev = AFSC_EV_NONE;
    afsc_cfg_t cfg;
    int n_errors = 0, n_compared = 0, cyc = 0;
    afsc_event_t evs [6] = '{AFSC_EV_BAD_ADDR, AFSC_EV_OVERFLOW, AFSC_EV_UNCORR,
                             AFSC_EV_VOLT_INT, AFSC_EV_SPARE, AFSC_EV_WR_FAIL};
    logic [7:0] ecd [6] = '{8'h21, 8'h2F, 8'h11, 8'h36, 8'h3A, 8'h03};
    logic [7:0] subs [15] = '{8'h05, 8'h85, 8'h09, 8'h89, 8'h0A, 8'h8A, 8'h55, 8'hAA,
                              8'h66, 8'hCC, 8'h69, 8'h96, 8'h97, 8'hBB, 8'h9A};
    always #5 clk = ~clk;
    afsc_host afsc_host_i (.i_clk(clk), .i_done(done), .o_cmd_valid(cv),
                           .o_cmd_code(code), .o_taskfile(tf));
    // narrower head range so the bad-head seek path can be reached
    afsc_core #(.MAX_HEAD(4'h7)) afsc_core_i (.i_clk(clk), .i_reset(reset),
        .i_cmd_valid(cv),
        .i_cmd_code(code), .i_taskfile(tf), .i_pc_card_mode(pc),
        .i_data_reg_access(dra), .i_flush_done(fdone), .i_event_valid(evv),
        .i_event(ev), .o_busy(busy), .o_done(done), .o_error(err), .o_error_reg(ereg),
        .o_sense_code(sense), .o_cyl_lo(clo), .o_cyl_hi(chi), .o_flush_req(freq),
        .o_sixteen_bit_io_indicator(ind), .o_iordy_drive(iordy), .o_cfg(cfg));
    // flush store answers one cycle late, so completion must really wait
    always @(posedge clk) begin
        fdone <= freq;
        fl <= fl | freq;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, f, s, input logic [3:0] h = 0, input logic l = 0);
        afsc_taskfile_t t;
        t = '{f, s, 8'h00, 8'h00, 8'h00, l, h};
        afsc_host_i.issue(c, t, ok);
        chk(8'({ok, busy}), 8'h02);
    endtask
    task automatic sf(input logic [7:0] f, s);
        cmd(CMD_SETFEAT, f, s);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            evv <= 1'b1;
            ev  <= evs[i];
            @(posedge clk);
            evv <= 1'b0;
            @(posedge clk);
            #1 chk(sense, ecd[i]);
            cmd(CMD_SENSE, 8'h00, 8'h00);
            chk(ereg, ecd[i]);
        end
        $display("test sense done");
        cmd(8'h7A, 8'h00, 8'h00, 4'hF, 1'b1);
        chk(8'({err, ereg[4]}), 8'h03);
        cmd(CMD_SENSE, 8'h00, 8'h00);
        chk(ereg, 8'h2F);
        cmd(8'h70, 8'h00, 8'h00, 4'h0, 1'b1);
        chk(8'(err), 8'h00);
        cmd(8'h71, 8'h00, 8'h00, 4'h8, 1'b0);
        chk(8'({err, ereg[4]}), 8'h03);
        cmd(CMD_SENSE, 8'h00, 8'h00);
        chk(ereg, 8'h21);
        $display("test seek done");
        sf(8'h42, 8'h00);
        chk(ereg & 8'h04, 8'h04);
        cmd(CMD_SENSE, 8'h00, 8'h00);
        chk(ereg, 8'h1F);
        for (int i = 0; i < 15; i++) begin
            sf(subs[i], 8'h80);
            chk(8'(err), 8'h00);
        end
        chk(8'({clo, chi} == 16'h01FF), 8'h01);
        $display("test features done");
        sf(SF_XFER, {XT_PIO_FC, 3'h4});
        chk(8'({iordy, cfg.pio_mode}), 8'h0C);
        sf(SF_XFER, 8'h00);
        chk(8'({iordy, cfg.pio_mode}), 8'h00);
        sf(SF_XFER, {XT_PIO_DEF, XM_NO_IORDY});
        chk(8'({err, cfg.iordy_off}), 8'h01);
        sf(SF_XFER, {XT_PIO_FC, 3'h7});
        chk(8'({err, cfg.pio_mode}), 8'h08);
        sf(SF_XFER, {XT_MDMA, 3'h2});
        chk(8'({cfg.mdma_on, cfg.udma_on}), 8'h02);
        sf(SF_XFER, {XT_UDMA, 3'h3});
        chk(8'({cfg.mdma_on, cfg.udma_on, cfg.dma_mode}), 8'h0B);
        @(posedge clk) pc <= 1'b1;
        sf(SF_XFER, {XT_MDMA, 3'h1});
        chk(8'({err, cfg.udma_on}), 8'h03);
        @(posedge clk) pc <= 1'b0;
        sf(SF_XFER, 8'h10);
        chk(8'(err), 8'h01);
        $display("test transfer mode done");
        @(posedge clk) dra <= 1'b1;
        sf(SF_8BIT_ON, 8'h00); // 8-bit mode leaves the dma setting alone; udma stays on
        chk(8'(ind), 8'h00);
        sf(SF_8BIT_OFF, 8'h00);
        chk(8'(ind), 8'h01);
        sf(SF_WC_ON, 8'h00);
        sf(SF_WC_OFF, 8'h00);
        chk(8'({fl, cfg.write_cache}), 8'h02);
        $display("test byte lanes and cache done");
        print_verdict();
    end
endmodule
`default_nettype wire
